/* File: hdl/ssmf_flag_bank.sv */
// sticky clear-on-read flag bank with per-bit enable and one level irq.
// assumes: clear is a one-cycle pulse from a status register read.
`timescale 1ns/1ps
module ssmf_flag_bank #(
  parameter int W = 8
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  ssmf_evt_if.bank   evt
);

  logic [W-1:0] flag;
  logic         irq;

  // ---------------------------------------------------------------
  // flags: a set in the read cycle survives for the next read
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag[i] <= 1'b0;
        end else if (evt.set_pulse[i]) begin
          flag[i] <= 1'b1;
        end else if (evt.clear) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // irq registered from the next flag value so it tracks the flags exactly; an enable change reaches it one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((flag & {W{~evt.clear}}) | evt.set_pulse) & evt.enable);
    end
  end

  assign evt.flags = flag;
  assign evt.irq   = irq;

endmodule

/* File: hdl/ssmf_top.sv */
// top of the per-channel message event flag block.
// assumes: message inputs come from the receive decoder on CORE_CLK;
// the transmitter pulses TX_MSG_SENT once per completed message copy.
`timescale 1ns/1ps
module ssmf_top #(
  parameter int MSG_W = 6
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RSTN,
  input  wire logic [15:0]      ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  input  wire logic             RX_MSG_VALID,
  input  wire logic [MSG_W-1:0] RX_MSG,
  input  wire logic             RX_FILTER_OK,
  input  wire logic             TX_MSG_SENT,
  output logic      [MSG_W-1:0] TX_MSG,
  output logic                  TX_ACTIVE,
  output logic                  IRQ
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]       event_enable;
  logic [7:0]       unstable_enable;
  logic [MSG_W-1:0] match_val [3];
  logic [MSG_W-1:0] rx_sync_msg_reg;
  logic [MSG_W-1:0] filt_msg;
  logic             filt_seen;
  logic             rx_seen;
  logic [7:0]       tx_repeat_count;
  logic [7:0]       tx_left;
  logic [MSG_W-1:0] tx_sync_msg_reg;
  ssmf_pkg::ssmf_tx_state_t tx_state;
  logic [7:0]       ev_pulse;
  logic [7:0]       un_pulse;
  logic             wr_ev;
  logic             tx_done;
  logic [11:0]      ofs;

  ssmf_evt_if #(.W(8)) ev_if ();
  ssmf_evt_if #(.W(8)) un_if ();

  assign ofs = ADDR[11:0];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // enables: reserved bits forced to zero so they never gate anything
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      event_enable    <= ssmf_pkg::RST_REG;
      unstable_enable <= ssmf_pkg::RST_REG;
      match_val[0]    <= '0;
      match_val[1]    <= '0;
      match_val[2]    <= '0;
      tx_repeat_count <= ssmf_pkg::RST_TX_REPEAT;
    end else if (WR) begin
      case (ofs)
        ssmf_pkg::OFS_EVENT_ENABLE:
          event_enable <= WDATA & ssmf_pkg::EVENT_MASK;
        ssmf_pkg::OFS_UNSTABLE_ENABLE:
          unstable_enable <= WDATA & ssmf_pkg::UNSTABLE_MASK;
        ssmf_pkg::OFS_MATCH_ONE:   match_val[0] <= WDATA[MSG_W-1:0];
        ssmf_pkg::OFS_MATCH_TWO:   match_val[1] <= WDATA[MSG_W-1:0];
        ssmf_pkg::OFS_MATCH_THREE: match_val[2] <= WDATA[MSG_W-1:0];
        ssmf_pkg::OFS_TX_REPEAT:   tx_repeat_count <= WDATA;
        default: ;
      endcase
    end
  end

  assign wr_ev = WR && (ofs == ssmf_pkg::OFS_TX_MSG);

  // ---------------------------------------------------------------
  // receive side: raw and filtered message tracking
  // ---------------------------------------------------------------
  // raw register follows every valid message; filtered copy only on
  // filter approval, so change detection ignores unconfirmed codes
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_sync_msg_reg <= '0;
      rx_seen         <= 1'b0;
      filt_msg        <= '0;
      filt_seen       <= 1'b0;
    end else begin
      if (RX_MSG_VALID) begin
        rx_sync_msg_reg <= RX_MSG;
        rx_seen         <= 1'b1;
      end
      if (RX_MSG_VALID && RX_FILTER_OK) begin
        filt_msg  <= RX_MSG;
        filt_seen <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit side: repeat counter for the outgoing message
  // ---------------------------------------------------------------
  // a zero repeat count is taken as one copy so the empty flag fires
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_state        <= ssmf_pkg::TX_IDLE;
      tx_left         <= 8'h00;
      tx_sync_msg_reg <= '0;
      tx_done         <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      case (tx_state)
        ssmf_pkg::TX_IDLE: begin
          if (wr_ev) begin
            tx_sync_msg_reg <= WDATA[MSG_W-1:0];
            tx_left  <= (tx_repeat_count == 8'h00) ? 8'h01
                                                   : tx_repeat_count;
            tx_state <= ssmf_pkg::TX_SEND;
          end
        end
        ssmf_pkg::TX_SEND: begin
          if (TX_MSG_SENT) begin
            if (tx_left == 8'h01) begin
              tx_done  <= 1'b1;
              tx_state <= ssmf_pkg::TX_IDLE;
            end
            tx_left <= tx_left - 8'h01;
          end
        end
        default: tx_state <= ssmf_pkg::TX_IDLE;
      endcase
    end
  end

  assign TX_MSG    = tx_sync_msg_reg;

  // busy pin held in its own flop, mirroring the sequencer state, so the
  // pin never shows a decode of the state bits
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_ACTIVE <= 1'b0;
    end else if (tx_state == ssmf_pkg::TX_IDLE) begin
      TX_ACTIVE <= wr_ev;
    end else if (tx_state != ssmf_pkg::TX_SEND) begin
      TX_ACTIVE <= 1'b0;
    end else if (TX_MSG_SENT && (tx_left == 8'h01)) begin
      TX_ACTIVE <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  // match and change events need filter validation; full does not
  always_comb begin
    ev_pulse = 8'h00;
    un_pulse = 8'h00;
    if (RX_MSG_VALID && RX_FILTER_OK) begin
      ev_pulse[ssmf_pkg::BIT_MATCH_THREE] = (RX_MSG == match_val[2]);
      ev_pulse[ssmf_pkg::BIT_MATCH_TWO]   = (RX_MSG == match_val[1]);
      ev_pulse[ssmf_pkg::BIT_MATCH_ONE]   = (RX_MSG == match_val[0]);
      ev_pulse[ssmf_pkg::BIT_CODE_CHANGE] =
        filt_seen && (RX_MSG != filt_msg);
    end
    ev_pulse[ssmf_pkg::BIT_RX_FULL]  = RX_MSG_VALID;
    ev_pulse[ssmf_pkg::BIT_TX_EMPTY] = tx_done;
    // unstable only once a first valid message is held
    un_pulse[ssmf_pkg::BIT_UNSTABLE] =
      RX_MSG_VALID && rx_seen && (RX_MSG != rx_sync_msg_reg);
  end

  // ---------------------------------------------------------------
  // flag banks
  // ---------------------------------------------------------------
  assign ev_if.set_pulse = ev_pulse & ssmf_pkg::EVENT_MASK;
  assign ev_if.enable    = event_enable;
  assign ev_if.clear     = RD && (ofs == ssmf_pkg::OFS_EVENT_STATUS);
  assign un_if.set_pulse = un_pulse;
  assign un_if.enable    = unstable_enable;
  assign un_if.clear     = RD && (ofs == ssmf_pkg::OFS_UNSTABLE_STATUS);

  ssmf_flag_bank #(.W(8)) u_ev (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .evt   (ev_if.bank)
  );

  ssmf_flag_bank #(.W(8)) u_un (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .evt   (un_if.bank)
  );

  // combined interrupt line, registered
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= ev_if.irq | un_if.irq;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ofs)
        ssmf_pkg::OFS_EVENT_STATUS:    RDATA <= ev_if.flags;
        ssmf_pkg::OFS_EVENT_ENABLE:    RDATA <= event_enable;
        ssmf_pkg::OFS_UNSTABLE_STATUS: RDATA <= un_if.flags;
        ssmf_pkg::OFS_UNSTABLE_ENABLE: RDATA <= unstable_enable;
        ssmf_pkg::OFS_MATCH_ONE:       RDATA <= 8'(match_val[0]);
        ssmf_pkg::OFS_MATCH_TWO:       RDATA <= 8'(match_val[1]);
        ssmf_pkg::OFS_MATCH_THREE:     RDATA <= 8'(match_val[2]);
        ssmf_pkg::OFS_RX_MSG:          RDATA <= 8'(rx_sync_msg_reg);
        ssmf_pkg::OFS_TX_MSG:          RDATA <= 8'(tx_sync_msg_reg);
        ssmf_pkg::OFS_TX_REPEAT:       RDATA <= tx_repeat_count;
        default:                       RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // receive steps: a filtered hit, a filtered change, a raw change
  sequence s_filtered_hit(int k);
    RX_MSG_VALID && RX_FILTER_OK && (RX_MSG == match_val[k]);
  endsequence

  sequence s_filtered_change;
    RX_MSG_VALID && RX_FILTER_OK && filt_seen && (RX_MSG != filt_msg);
  endsequence

  sequence s_raw_change;
    RX_MSG_VALID && rx_seen && (RX_MSG != rx_sync_msg_reg);
  endsequence

  // transmit steps: load of a new message, then each copy sent
  sequence s_tx_load;
    wr_ev && (tx_state == ssmf_pkg::TX_IDLE);
  endsequence

  sequence s_early_copy;
    (tx_state == ssmf_pkg::TX_SEND) && TX_MSG_SENT && (tx_left != 8'h01);
  endsequence

  sequence s_last_copy;
    (tx_state == ssmf_pkg::TX_SEND) && TX_MSG_SENT && (tx_left == 8'h01);
  endsequence

  // match flags: set on the edge after a filtered hit; match one never without it
  a_match_three_set: assert property (
    s_filtered_hit(2) |=> ev_if.flags[7])
    else $error("match three not flagged");
  a_match_two_set: assert property (
    s_filtered_hit(1) |=> ev_if.flags[6])
    else $error("match two not flagged");
  a_match_one_set: assert property (
    s_filtered_hit(0) |=> ev_if.flags[1])
    else $error("match one not flagged");
  a_match_needs_filter: assert property (
    !RX_FILTER_OK && !ev_if.flags[1] && !ev_if.clear |=> !ev_if.flags[1])
    else $error("match flagged without filter");

  // full flag ignores the filter, change flag depends on it
  a_full_unfiltered: assert property (
    RX_MSG_VALID |=> ev_if.flags[3])
    else $error("full flag missed");
  a_change_set: assert property (
    s_filtered_change |=> ev_if.flags[0])
    else $error("change flag missed");
  a_change_needs_filter: assert property (
    !(RX_MSG_VALID && RX_FILTER_OK) && !ev_if.flags[0] && !ev_if.clear
    |=> !ev_if.flags[0])
    else $error("change flagged without filter");

  // transmit: load, no early empty, empty after the last copy
  a_tx_starts: assert property (
    s_tx_load |=> TX_ACTIVE && (TX_MSG == $past(WDATA[MSG_W-1:0])))
    else $error("tx message not loaded");
  a_tx_active_state: assert property (
    TX_ACTIVE == (tx_state == ssmf_pkg::TX_SEND))
    else $error("tx active disagrees with state");
  a_empty_not_early: assert property (
    s_early_copy |=> !tx_done)
    else $error("empty before last copy");
  a_empty_after_repeats: assert property (
    s_last_copy |=> ##1 ev_if.flags[2])
    else $error("empty flag missed");

  // reserved bits and the unstable flag
  a_reserved_zero: assert property (
    ev_if.flags[5:4] == 2'b00 && event_enable[5:4] == 2'b00)
    else $error("reserved bits set");
  a_unstable_first: assert property (
    !rx_seen |-> !un_if.flags[6])
    else $error("unstable before first message");
  a_unstable_set: assert property (
    s_raw_change |=> un_if.flags[6])
    else $error("unstable flag missed");
  a_unstable_clear: assert property (
    un_if.clear && un_pulse == 8'h00 |=> un_if.flags == 8'h00)
    else $error("unstable read did not clear");

  // a clearing read still returns the flags as they stood before it
  a_clear_on_read: assert property (
    ev_if.clear && ev_pulse == 8'h00 |=> ev_if.flags == 8'h00)
    else $error("read did not clear");
  a_read_returns_flags: assert property (
    ev_if.clear |=> RDATA == $past(ev_if.flags))
    else $error("status read lost flags");

  // interrupt: follows enabled flags, silent once all enables have been zero for three cycles
  a_irq_follows: assert property (
    |(ev_if.flags & event_enable) || |(un_if.flags & unstable_enable)
    |-> ##[1:2] IRQ)
    else $error("irq missing");
  a_bank_irq_level: assert property (
    ev_if.irq == |(ev_if.flags & $past(event_enable))
    && un_if.irq == |(un_if.flags & $past(unstable_enable)))
    else $error("bank irq out of step");
  a_irq_masked: assert property (
    event_enable == 8'h00 && unstable_enable == 8'h00
    ##1 event_enable == 8'h00 && unstable_enable == 8'h00
    ##1 event_enable == 8'h00 && unstable_enable == 8'h00 |-> !IRQ)
    else $error("irq while disabled");

endmodule

/* File: shared/ssmf_evt_if.sv */
// interface carrying per-bit event pulses from the top module into the
// sticky flag bank, and the flags and interrupt back.
// assumes: single clock domain.
`timescale 1ns/1ps
interface ssmf_evt_if #(parameter int W = 8);
  logic [W-1:0] set_pulse;
  logic [W-1:0] enable;
  logic         clear;
  logic [W-1:0] flags;
  logic         irq;

  modport src (output set_pulse, output enable, output clear,
               input flags, input irq);
  modport bank (input set_pulse, input enable, input clear,
                output flags, output irq);
endinterface

/* File: shared/ssmf_pkg.sv */
// package for the message event flag block: register map, bit positions,
// reset values and state codes.
// assumes: one channel per instance, channel digit decoded outside.
package ssmf_pkg;

  // ---------------------------------------------------------------
  // register offsets (low 12 bits; channel nibble above)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_EVENT_STATUS    = 12'hB70;
  localparam logic [11:0] OFS_EVENT_ENABLE    = 12'hB71;
  localparam logic [11:0] OFS_UNSTABLE_STATUS = 12'hB74;
  localparam logic [11:0] OFS_UNSTABLE_ENABLE = 12'hB75;
  localparam logic [11:0] OFS_MATCH_ONE       = 12'hB78;
  localparam logic [11:0] OFS_MATCH_TWO       = 12'hB79;
  localparam logic [11:0] OFS_MATCH_THREE     = 12'hB7A;
  localparam logic [11:0] OFS_RX_MSG          = 12'hB7B;
  localparam logic [11:0] OFS_TX_MSG          = 12'hB7C;
  localparam logic [11:0] OFS_TX_REPEAT       = 12'hB7D;

  // ---------------------------------------------------------------
  // event status / enable bit positions
  // ---------------------------------------------------------------
  localparam int BIT_MATCH_THREE = 7;
  localparam int BIT_MATCH_TWO   = 6;
  localparam int BIT_RX_FULL     = 3;
  localparam int BIT_TX_EMPTY    = 2;
  localparam int BIT_MATCH_ONE   = 1;
  localparam int BIT_CODE_CHANGE = 0;
  localparam int BIT_UNSTABLE    = 6;

  // writable / implemented bits; bits 5:4 reserved and read zero
  localparam logic [7:0] EVENT_MASK    = 8'hCF;
  localparam logic [7:0] UNSTABLE_MASK = 8'h40;

  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] RST_TX_REPEAT = 8'h01;

  // ---------------------------------------------------------------
  // transmit sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } ssmf_tx_state_t;

endpackage

/* File: verification/ssmf_far_end.sv */
// far-end model: remote terminal sending messages, counting tx copies.
// assumes: send is entered right after a rising clock edge.
`timescale 1ns/1ps
module ssmf_far_end #(
  parameter int MSG_W = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tx_active,
  input  wire logic [3:0]       gap,
  output logic                  rx_valid,
  output logic      [MSG_W-1:0] rx_msg,
  output logic                  rx_filter_ok,
  output logic                  tx_sent,
  output logic      [7:0]       n_sent
);
  logic [3:0] cnt;

  // quiet lines at start
  initial begin
    rx_valid     = 1'b0;
    rx_msg       = '0;
    rx_filter_ok = 1'b0;
  end

  // one message for one cycle; afterwards the inverse, so stale data
  // can never pass for a fresh message
  task automatic send(input logic [MSG_W-1:0] m, input logic f);
    @(posedge clk);
    rx_valid     <= 1'b1;
    rx_msg       <= m;
    rx_filter_ok <= f;
    @(posedge clk);
    rx_valid     <= 1'b0;
    rx_msg       <= ~m;
    rx_filter_ok <= ~f;
  endtask

  // a copy leaves every gap cycles while the sender is active;
  // gap of two or more keeps a stray copy out after the last one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 4'h0;
      tx_sent <= 1'b0;
      n_sent  <= 8'h00;
    end else begin
      tx_sent <= 1'b0;
      if (!tx_active) begin
        cnt <= 4'h0;
      end else if (cnt == gap - 4'h1) begin
        cnt     <= 4'h0;
        tx_sent <= 1'b1;
        n_sent  <= n_sent + 8'h01;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* File: verification/ssmf_top_tb.sv */
// bench for the message event flag block: registers, flags, irq, tx.
// assumes: far-end model drives the message and tx copy inputs.
`timescale 1ns/1ps
module ssmf_top_tb;
  logic        clk, rstn, wr_s, rd_s, irq, tx_act, rxv, rxf, txs, ei;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, d, n_sent;
  logic [5:0]  rxm, txm;
  logic [3:0]  gap;
  logic [47:0] r;
  int          mismatches, n_tests;
  // msg, filter, event enable, unstable enable, event flags, unstable
  localparam logic [47:0] ROWS [9] = '{
    48'h05_01_00_00_0A_00, 48'h0A_01_02_00_49_40, 48'h11_01_80_00_89_40,
    48'h11_00_08_00_08_00, 48'h05_00_01_00_08_40, 48'h05_01_02_40_0B_00,
    48'h0A_01_01_00_49_40, 48'h3F_01_04_40_09_40, 48'h3F_01_37_00_08_00};
  localparam logic [11:0] REGS [4] = '{12'hB70, 12'hB71, 12'hB74, 12'hB75};

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ssmf_top u_ssmf_top (
    .CORE_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .RX_MSG_VALID(rxv), .RX_MSG(rxm),
    .RX_FILTER_OK(rxf), .TX_MSG_SENT(txs), .TX_MSG(txm),
    .TX_ACTIVE(tx_act), .IRQ(irq));

  ssmf_far_end u_ssmf_far_end (
    .clk(clk), .rst_n(rstn), .tx_active(tx_act), .gap(gap),
    .rx_valid(rxv), .rx_msg(rxm), .rx_filter_ok(rxf), .tx_sent(txs),
    .n_sent(n_sent));

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  // channel nibble 3 on every access: it must be ignored
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= {4'h3, a};
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic bus_rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= {4'h3, a};
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] v;
    bus_rd(a, v);
    chk8(v, e);
  endtask

  // bounded waits; running out is a mismatch and ends the run
  task automatic wait_sig(input logic [7:0] tgt, input logic on_irq);
    for (int i = 0; i < 80; i++) begin
      if (on_irq ? irq === 1'b1 : n_sent === tgt) return;
      @(posedge clk);
    end
    mismatches++;
    $display("Error t=%0t wait timed out", $time);
    conclude();
  endtask

  task automatic txrun(input logic [7:0] rep, input logic [5:0] m,
                       input logic [3:0] g);
    logic [7:0] base;
    base = n_sent;
    gap <= g;
    bus_wr(ssmf_pkg::OFS_TX_REPEAT, rep);
    bus_wr(ssmf_pkg::OFS_TX_MSG, {2'b00, m});
    repeat (2) @(posedge clk);
    chk8({2'b00, txm}, {2'b00, m});
    chkb(tx_act, 1'b1);
    if (rep > 8'h01) begin
      wait_sig(base + rep - 8'h01, 1'b0);
      rchk(ssmf_pkg::OFS_EVENT_STATUS, 8'h00);
    end
    wait_sig(8'h00, 1'b1);
    chk8(n_sent, base + rep);
    rchk(ssmf_pkg::OFS_EVENT_STATUS, 8'h04);
    repeat (2) @(posedge clk);
    chkb(irq, 1'b0);
  endtask

  task automatic conclude();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    gap = 4'h8;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(REGS[i], ssmf_pkg::RST_REG);
    rchk(ssmf_pkg::OFS_TX_REPEAT, ssmf_pkg::RST_TX_REPEAT);
    bus_wr(ssmf_pkg::OFS_EVENT_ENABLE, 8'hFF);
    rchk(ssmf_pkg::OFS_EVENT_ENABLE, ssmf_pkg::EVENT_MASK);
    bus_wr(ssmf_pkg::OFS_UNSTABLE_ENABLE, 8'hFF);
    rchk(ssmf_pkg::OFS_UNSTABLE_ENABLE, ssmf_pkg::UNSTABLE_MASK);
    bus_wr(ssmf_pkg::OFS_EVENT_STATUS, 8'hFF);
    rchk(ssmf_pkg::OFS_EVENT_STATUS, 8'h00);
    bus_wr(12'hB72, 8'hFF);
    rchk(12'hB72, 8'h00);
    chkb(irq, 1'b0);
    bus_wr(ssmf_pkg::OFS_MATCH_ONE, 8'h05);
    bus_wr(ssmf_pkg::OFS_MATCH_TWO, 8'h0A);
    bus_wr(ssmf_pkg::OFS_MATCH_THREE, 8'h11);
    // each row: enables, one message, irq, flags, clear on read
    for (int i = 0; i < 9; i++) begin
      r = ROWS[i];
      bus_wr(ssmf_pkg::OFS_EVENT_ENABLE, r[31:24]);
      bus_wr(ssmf_pkg::OFS_UNSTABLE_ENABLE, r[23:16]);
      u_ssmf_far_end.send(r[45:40], r[32]);
      repeat (3) @(posedge clk);
      ei = |(r[15:8] & r[31:24]) | |(r[7:0] & r[23:16]);
      chkb(irq, ei);
      rchk(ssmf_pkg::OFS_RX_MSG, {2'b00, r[45:40]});
      rchk(ssmf_pkg::OFS_EVENT_STATUS, r[15:8]);
      rchk(ssmf_pkg::OFS_UNSTABLE_STATUS, r[7:0]);
      rchk(ssmf_pkg::OFS_EVENT_STATUS, 8'h00);
      repeat (2) @(posedge clk);
      chkb(irq, 1'b0);
    end
    // an event landing on the clearing read survives to the next read
    fork
      u_ssmf_far_end.send(6'h2A, 1'b1);
      bus_rd(ssmf_pkg::OFS_EVENT_STATUS, d);
    join
    chk8(d, 8'h00);
    rchk(ssmf_pkg::OFS_EVENT_STATUS, 8'h09);
    rchk(ssmf_pkg::OFS_UNSTABLE_STATUS, 8'h40);
    bus_wr(ssmf_pkg::OFS_EVENT_ENABLE, 8'h04);
    bus_wr(ssmf_pkg::OFS_UNSTABLE_ENABLE, 8'h00);
    txrun(8'h03, 6'h15, 4'h8);
    txrun(8'h01, 6'h2A, 4'h3);
    conclude();
  end
endmodule
